//--- common/srctl_pkg.sv
/*
 Constants for the soft reset control block: register offset, field
 positions, reset values and timing counts.
 Assumes a byte-wide register port driven by a control-port front end.
*/
package srctl_pkg;
  localparam logic [7:0] SRCTL_OFS = 8'h01;
  localparam int MOD_BIT = 4;
  localparam int DEF_BIT = 0;
  localparam logic [7:0] SRCTL_RST = 8'h00;
  localparam int COEF_WORDS = 256;
  localparam int MOD_PULSE_NS = 200;
  localparam int CLK_NS = 50;
  localparam int MOD_PULSE_CYC = (MOD_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEF_PULSE_CYC = 1;
  typedef enum {SR_IDLE, SR_MOD, SR_CLEAR, SR_DEF} srctl_state_t;
endpackage

//--- common/srctl_clr_if.sv
/*
 Interface between the reset sequencer and its coefficient clear walker.
 Assumes both sides share mclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface srctl_clr_if #(parameter int AW = 8);
  logic start;
  logic busy;
  logic [AW-1:0] addr;
  logic wr;
  modport seq (output start, input busy, input addr, input wr);
  modport walk (input start, output busy, output addr, output wr);
endinterface
`default_nettype wire

//--- hw/srctl_clear_walk.sv
/*
 Walks every coefficient memory address once, issuing a zero write each
 cycle, after a start pulse. Assumes start only while idle.
*/
`timescale 1ns/1ns
`default_nettype none
module srctl_clear_walk #(
  parameter int WORDS = srctl_pkg::COEF_WORDS,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  srctl_clr_if.walk c
);
  import srctl_pkg::*;
  logic busy_q;
  logic [AW-1:0] addr_q;
  logic last;
  assign last = (addr_q == AW'(WORDS - 1));
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      addr_q <= '0;
    end else if (c.start) begin
      busy_q <= 1'b1;
      addr_q <= '0;
    end else if (busy_q) begin
      busy_q <= !last;
      addr_q <= last ? '0 : addr_q + 1'b1;
    end
  end
  assign c.busy = busy_q;
  assign c.addr = addr_q;
  assign c.wr = busy_q;
endmodule // srctl_clear_walk
`default_nettype wire

//--- hw/srctl_top.sv
/*
 Soft reset control register and its sequencer. Produces reset pulses to
 the filter, converters, processor and mode registers, and clears the
 coefficient memory after a module reset.
 Assumes a control-port front end presenting byte writes and reads on
 mclk, and a standby level from the power logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module srctl_top #(
  parameter int WORDS = srctl_pkg::COEF_WORDS,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic standby_request,
  output logic standby_active,
  output logic module_reset,
  output logic dsp_reset,
  output logic defaults_reset,
  output logic rom_select,
  output logic coef_clr_wr,
  output logic [AW-1:0] coef_clr_addr,
  output logic busy
);
  import srctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  srctl_clr_if #(.AW(AW)) clr ();
  srctl_clear_walk #(.WORDS(WORDS), .AW(AW)) u_walk (
    .mclk(mclk),
    .rst(rst),
    .c(clr)
  );

  srctl_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic module_reset_trigger_q;
  logic register_defaults_trigger_q;
  logic rom_q;
  logic hit_wr;
  logic mod_req;
  logic def_req;

  ////////////////////////////////////////////////////////////////////////
  assign hit_wr = reg_wr && (reg_addr == SRCTL_OFS);
  // Reserved bits are not looked at, except bit 7, which sets the execution source
  assign mod_req = hit_wr && reg_wdata[MOD_BIT] && standby_request;
  assign def_req = hit_wr && reg_wdata[DEF_BIT];
  assign standby_active = standby_request;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    clr.start = 1'b0;
    case (st_q)
      SR_IDLE: begin
        // Module reset wins if both are written together in standby
        if (mod_req) begin
          st_d = SR_MOD;
          cnt_d = 8'(MOD_PULSE_CYC - 1);
        end else if (def_req) begin
          st_d = SR_DEF;
          cnt_d = 8'(DEF_PULSE_CYC - 1);
        end
      end
      SR_MOD: begin
        if (cnt_q == 8'h00) begin
          st_d = SR_CLEAR;
          clr.start = 1'b1;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      SR_CLEAR: begin
        if (!clr.busy) begin
          st_d = SR_IDLE;
        end
      end
      SR_DEF: begin
        if (cnt_q == 8'h00) begin
          st_d = SR_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = SR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= SR_IDLE;
      cnt_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger bits mirror the sequence; they drop by themselves when done
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      module_reset_trigger_q <= SRCTL_RST[MOD_BIT];
      register_defaults_trigger_q <= SRCTL_RST[DEF_BIT];
    end else begin
      module_reset_trigger_q <= (st_d == SR_MOD) ||
        (st_d == SR_CLEAR);
      register_defaults_trigger_q <= (st_d == SR_DEF);
    end
  end

  // Execution source: back to ROM on a defaults reset; data memory kept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rom_q <= 1'b1;
    end else if (st_q == SR_DEF) begin
      rom_q <= 1'b1;
    end else if (hit_wr && !reg_wdata[DEF_BIT] && reg_wdata[7]) begin
      rom_q <= 1'b0;
    end
  end

  assign module_reset = (st_q == SR_MOD);
  assign dsp_reset = (st_q == SR_MOD) || (st_q == SR_CLEAR);
  assign defaults_reset = (st_q == SR_DEF);
  assign rom_select = rom_q;
  assign coef_clr_wr = clr.wr;
  assign coef_clr_addr = clr.addr;
  assign busy = (st_q != SR_IDLE);
  // Reserved bits read 0; a refused module trigger never shows
  assign reg_rdata = {3'h0, module_reset_trigger_q, 3'h0,
    register_defaults_trigger_q};

  ////////////////////////////////////////////////////////////////////////
  property p_mod_stby;
    @(posedge mclk) disable iff (rst)
      (st_q == SR_IDLE && hit_wr && reg_wdata[MOD_BIT] && !standby_request)
      |=> !module_reset;
  endproperty
  a_mod_stby: assert property (p_mod_stby)
    else $error("mod reset outside stby");

  property p_mod_len;
    @(posedge mclk) disable iff (rst)
      $rose(module_reset) |-> module_reset [*4] ##1 !module_reset;
  endproperty
  a_mod_len: assert property (p_mod_len)
    else $error("module pulse length");

  property p_clear_follows;
    @(posedge mclk) disable iff (rst)
      $fell(module_reset) |-> coef_clr_wr && coef_clr_addr == '0;
  endproperty
  a_clear_follows: assert property (p_clear_follows)
    else $error("no clear");

  property p_mod_selfclr;
    @(posedge mclk) disable iff (rst)
      $rose(reg_rdata[MOD_BIT]) |-> ##[1:300] !reg_rdata[MOD_BIT];
  endproperty
  a_mod_selfclr: assert property (p_mod_selfclr)
    else $error("trigger stuck");

  property p_def_pulse;
    @(posedge mclk) disable iff (rst)
      (st_q == SR_IDLE && def_req && !mod_req)
      |=> defaults_reset ##1 !defaults_reset;
  endproperty
  a_def_pulse: assert property (p_def_pulse)
    else $error("defaults pulse");

  property p_rom;
    @(posedge mclk) disable iff (rst)
      defaults_reset |=> rom_select;
  endproperty
  a_rom: assert property (p_rom)
    else $error("not back to ROM");

  property p_def_selfclr;
    @(posedge mclk) disable iff (rst)
      reg_rdata[DEF_BIT] |=> !reg_rdata[DEF_BIT];
  endproperty
  a_def_selfclr: assert property (p_def_selfclr)
    else $error("defaults stuck");

  property p_rsvd;
    @(posedge mclk) disable iff (rst)
      (!busy && hit_wr && !reg_wdata[MOD_BIT] && !reg_wdata[DEF_BIT])
      |=> !busy && reg_rdata == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits acted on");
endmodule // srctl_top
`default_nettype wire

//--- tb/srctl_host.sv
/*
 Host model: byte writes to the soft reset control register.
 Assumes the bench calls wr and that mclk is free running.
*/
`timescale 1ns/1ns
`default_nettype none
module srctl_host (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic standby_request
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    standby_request = 1'b0;
  end
  // Standby is held after the write, so a restore never meets a running core
  task automatic wr(input logic [7:0] d, input logic sb);
    @(negedge mclk);
    standby_request = sb;
    reg_addr = srctl_pkg::SRCTL_OFS;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Released bus must not keep the last value
    reg_addr = ~reg_addr;
    reg_wdata = ~d;
  endtask
endmodule // srctl_host
`default_nettype wire

//--- tb/testbench.sv
/*
 Self-checking bench for the soft reset control block.
 Assumes the host model in srctl_host and a short coefficient memory.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import srctl_pkg::*;
  localparam int W = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, coef_clr_addr;
  logic reg_wr, standby_request, standby_active, module_reset, dsp_reset;
  logic defaults_reset, rom_select, coef_clr_wr, busy;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] d;
  logic sb;
  srctl_host i_srctl_host (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .standby_request(standby_request));
  srctl_top #(.WORDS(W), .AW(8)) i_srctl_top (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .standby_request(standby_request),
    .standby_active(standby_active), .module_reset(module_reset),
    .dsp_reset(dsp_reset), .defaults_reset(defaults_reset),
    .rom_select(rom_select), .coef_clr_wr(coef_clr_wr),
    .coef_clr_addr(coef_clr_addr), .busy(busy));
  always #25 mclk = ~mclk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic mod_run(input logic [7:0] v);
    int k;
    i_srctl_host.wr(v, 1'b1);
    for (k = 0; k <= 5 + W; k++) begin
      `CHK("module_reset", k < 4, module_reset)
      `CHK("dsp_reset", k <= 4 + W, dsp_reset)
      `CHK("coef_clr_wr", k >= 4 && k < 4 + W, coef_clr_wr)
      if (coef_clr_wr === 1'b1)
        `CHK("coef_clr_addr", 8'(k - 4), coef_clr_addr)
      `CHK("rdata_mod", k <= 4 + W, reg_rdata[MOD_BIT])
      `CHK("mod_busy", k <= 4 + W, busy)
      `CHK("defaults_reset", 1'b0, defaults_reset)
      @(negedge mclk);
    end
  endtask
  // Module trigger is taken only in standby
  function automatic logic exp_mod(input logic [7:0] v, input logic s);
    return v[MOD_BIT] && s;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5923));
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    `CHK("rdata_rst", 8'h00, reg_rdata)
    `CHK("rom_rst", 1'b1, rom_select)
    mod_run(8'h10);
    mod_run(8'h11);
    i_srctl_host.wr(8'h10, 1'b0);
    `CHK("refused_mod", 1'b0, module_reset)
    `CHK("refused_read", 8'h00, reg_rdata)
    `CHK("standby", 1'b0, standby_active)
    i_srctl_host.wr(8'h6E, 1'b1);
    `CHK("reserved_busy", 1'b0, busy)
    `CHK("reserved_read", 8'h00, reg_rdata)
    i_srctl_host.wr(8'h80, 1'b1);
    `CHK("rom_off", 1'b0, rom_select)
    i_srctl_host.wr(8'h01, 1'b1);
    `CHK("defaults_reset", 1'b1, defaults_reset)
    `CHK("rdata_def", 8'h01, reg_rdata)
    @(negedge mclk);
    `CHK("def_clear", 1'b0, defaults_reset)
    `CHK("rdata_def_clr", 8'h00, reg_rdata)
    `CHK("rom_back", 1'b1, rom_select)
    repeat (12) begin
      d = 8'($urandom) & 8'hFE;
      sb = 1'($urandom);
      i_srctl_host.wr(d, sb);
      `CHK("rand_busy", exp_mod(d, sb), busy)
      `CHK("rand_mod", exp_mod(d, sb), module_reset)
      `CHK("rand_def", 1'b0, defaults_reset)
      `CHK("rand_rsvd", 8'h00, reg_rdata & 8'hEE)
      repeat (6 + W) @(negedge mclk);
    end
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
